// >>> hdl/pdm_pkg.sv
/*
  Constants, register map and mode encoding of the power-down mode controller.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package pdm_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_MSTOP_A = 8'h00;
  localparam logic [7:0] OFS_MSTOP_B = 8'h04;
  localparam logic [7:0] OFS_MSTOP_C = 8'h08;
  localparam logic [7:0] OFS_SYSCLK  = 8'h0C;
  localparam logic [7:0] OFS_STANDBY = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] MSTOP_A_RESET = 8'h3F;
  localparam logic [7:0] MSTOP_B_RESET = 8'hFF;
  localparam logic [7:0] MSTOP_C_RESET = 8'hFF;
  localparam logic [2:0] DIV_RESET     = 3'h0;
  localparam logic [2:0] STS_RESET     = 3'h0;
  // ==========================================================================
  // Field positions
  localparam int TIMER_BIT   = 5;
  localparam int CONV_BIT    = 1;
  localparam int SER0_BIT    = 7;
  localparam int SER1_BIT    = 6;
  localparam int SER2_BIT    = 5;
  localparam int CAN_BIT     = 3;
  localparam int DIV_LSB     = 0;
  localparam int SSEL_BIT    = 7;
  localparam int STS_LSB     = 4;
  // ==========================================================================
  // Codes
  localparam logic [2:0] DIV_MAX      = 3'h5;
  localparam logic [2:0] STS_MAX      = 3'h5;
  localparam logic [2:0] STS_RESERVED = 3'h6;
  localparam logic [2:0] STS_NO_SET   = 3'h7;
  // ==========================================================================
  // Stabilization counting
  localparam int unsigned STAB_BASE_STATES = 8192;
  localparam int          STAB_CNT_W       = 19;
  // ==========================================================================
  // Synchronised pins
  localparam int         PIN_N     = 9;
  localparam int         PIN_HWSTB = 8;
  localparam int         PIN_RST   = 7;
  localparam int         PIN_NMI   = 6;
  localparam logic [8:0] PIN_IDLE  = 9'h1BF;
  // ==========================================================================
  // Operating modes
  typedef enum logic [2:0] {
    PDM_RUN,
    PDM_SLEEP,
    PDM_SWSTBY,
    PDM_OSCWAIT,
    PDM_RESET,
    PDM_HWSTBY
  } pdm_mode_e;
endpackage

// >>> hdl/pdm_clk_if.sv
/*
  Carrier between the controller and its bus master clock divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface pdm_clk_if;
  logic [2:0] div_code;
  logic       bm_tick;
  modport ctl (output div_code, input bm_tick);
  modport div (input div_code, output bm_tick);
endinterface // pdm_clk_if

// >>> hdl/pdm_divider.sv
/*
  Bus master clock-enable divider, divide by 1, 2, 4, 8, 16 or 32.
  Assumes the divider code changes only at a bus cycle boundary.
*/
`timescale 1ns/10ps
module pdm_divider (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic run,
  pdm_clk_if.div    cif
);
  logic [4:0] cnt;
  logic [4:0] mask;
  logic [5:0] span;

  // ==========================================================================
  // Terminal count
  // Reserved codes fall back to the undivided clock rather than a wild ratio.
  always_comb
  begin
    span = 6'h01 << cif.div_code;
    mask = 5'h00;
    if (cif.div_code != 3'h0 && cif.div_code <= pdm_pkg::DIV_MAX)
    begin
      mask = 5'(span - 6'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt         <= 5'h00;
      cif.bm_tick <= 1'b0;
    end
    else
    begin
      cif.bm_tick <= ce && run && (cnt == mask);
      if (ce && run)
      begin
        cnt <= (cnt == mask) ? 5'h00 : 5'(cnt + 5'h01);
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_div4_spacing;
    @(posedge clk) disable iff (!rst_n)
    (cif.bm_tick && cif.div_code == 3'h2 && $stable(cif.div_code)) |=> !cif.bm_tick[*3];
  endproperty
  a_div4_spacing: assert property (p_div4_spacing) else $error("div4 tick too soon");
endmodule // pdm_divider

// >>> hdl/pdm_top.sv
/*
  Power-down mode controller: module stop registers, medium-speed clock
  selection, sleep, software standby with stabilization wait, reset and
  hardware standby entry.
  Assumes the CPU core pulses sleep_exec for a SLEEP instruction, the bus
  signals bus_cycle_end, and pins arrive asynchronously.
*/
// What this block does
// - Module stop bit one stops, zero releases.
// - Reset: stop A top bits 0, rest 1.
// - Stop bits map timer, converter, serials, CAN.
// - Divider code 1 to 5 slows bus masters after cycle.
// - Non-master peripherals keep the full clock.
// - Bus accesses count in bus master states.
// - Divider zero returns high speed after cycle.
// - Sleep halts CPU, peripherals keep running.
// - Wake from sleep or standby keeps speed.
// - Reset pin or watchdog cancels medium speed.
// - Hardware standby pin low enters hardware standby.
// - Enabled unmasked interrupt ends sleep with exception.
// - Reset during sleep, release starts reset exception.
// - Standby stops CPU, peripherals, oscillator; serial/converter reinit.
// - Standby wakes by NMI, IRQ, reset, standby pin.
// - IRQ wakes only if enabled and unmasked.
// - Reset in standby restarts oscillator, clocks at once.
// - Stabilization code selects 8192 to 262144 states.
// - Module stop takes effect at bus cycle end.
// - Stopped peripheral registers are not accessible.
`timescale 1ns/10ps
module pdm_top #(
  parameter int unsigned STAB_BASE = pdm_pkg::STAB_BASE_STATES
) (
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  input  wire logic        sleep_exec,
  input  wire logic        bus_cycle_end,
  input  wire logic        wdt_reset,
  input  wire logic        int_request,
  input  wire logic        cpu_mask_all,
  input  wire logic [5:0]  irq_enable,
  input  wire logic        hw_standby_pin_n,
  input  wire logic        external_reset_pin_n,
  input  wire logic        nmi_pin,
  input  wire logic [5:0]  irq_pin_n,
  output      logic        cpu_halt,
  output      logic        chip_reset,
  output      logic        osc_enable,
  output      logic        peripheral_clock_enable,
  output      logic        bm_clock_enable,
  output      logic        medium_speed,
  output      logic        serial_converter_init,
  output      logic        int_exception_start,
  output      logic        reset_exception_start,
  output      logic [5:0]  peripheral_stop
);
  localparam int CW = pdm_pkg::STAB_CNT_W;

  logic                 rst_meta;
  logic                 rst_n;
  logic [8:0]           pin_raw;
  logic [8:0]           pin_s1;
  logic [8:0]           pin_s2;
  logic [8:0]           pin_s3;
  logic [8:0]           pin_lvl;
  pdm_pkg::pdm_mode_e   mode;
  pdm_pkg::pdm_mode_e   next_mode;
  logic [7:0]           module_stop_control_a;
  logic [7:0]           module_stop_control_b;
  logic [7:0]           module_stop_control_c;
  logic [2:0]           cpu_clock_divider_select;
  logic                 standby_select_bit;
  logic [2:0]           stabilize_time_select;
  logic [2:0]           eff_div;
  logic [CW-1:0]        stab_cnt;
  logic [CW-1:0]        stab_target;
  logic                 stab_done;
  logic                 irq_wake;
  logic                 sleep_wake;
  logic                 ack;
  logic                 in_reset;
  logic [7:0]           rd_val;
  pdm_clk_if            cif ();

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Reset release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  // A level is taken only when two stages agree, so a glitch shorter than a
  // clock never reaches the mode logic.
  assign pin_raw = {hw_standby_pin_n, external_reset_pin_n, nmi_pin, irq_pin_n};

  for (genvar i = 0; i < pdm_pkg::PIN_N; i++)
  begin : g_sync
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_s1[i]  <= pdm_pkg::PIN_IDLE[i];
        pin_s2[i]  <= pdm_pkg::PIN_IDLE[i];
        pin_s3[i]  <= pdm_pkg::PIN_IDLE[i];
        pin_lvl[i] <= pdm_pkg::PIN_IDLE[i];
      end
      else if (ce)
      begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i])
        begin
          pin_lvl[i] <= pin_s2[i];
        end
      end
    end
  end

  // ==========================================================================
  // Wake conditions and stabilization target
  always_comb
  begin
    irq_wake   = (|(~pin_lvl[5:0] & irq_enable)) && !cpu_mask_all;
    sleep_wake = pin_lvl[pdm_pkg::PIN_NMI] || (int_request && !cpu_mask_all);
    if (stabilize_time_select >= pdm_pkg::STS_RESERVED)
    begin
      stab_target = CW'(STAB_BASE) << pdm_pkg::STS_MAX;
    end
    else
    begin
      stab_target = CW'(STAB_BASE) << stabilize_time_select;
    end
    stab_done = (mode == pdm_pkg::PDM_OSCWAIT) && (stab_cnt == CW'(stab_target - 1'b1));
    in_reset  = (mode == pdm_pkg::PDM_RESET) || (mode == pdm_pkg::PDM_HWSTBY);
  end

  // ==========================================================================
  // Mode sequencing
  always_comb
  begin
    next_mode = mode;
    if (!pin_lvl[pdm_pkg::PIN_HWSTB])
    begin
      next_mode = pdm_pkg::PDM_HWSTBY;
    end
    else if (!pin_lvl[pdm_pkg::PIN_RST] || wdt_reset)
    begin
      next_mode = pdm_pkg::PDM_RESET;
    end
    else
    begin
      case (mode)
        pdm_pkg::PDM_RUN:
        begin
          if (sleep_exec)
          begin
            next_mode = standby_select_bit ? pdm_pkg::PDM_SWSTBY : pdm_pkg::PDM_SLEEP;
          end
        end
        pdm_pkg::PDM_SLEEP:
        begin
          if (sleep_wake)
          begin
            next_mode = pdm_pkg::PDM_RUN;
          end
        end
        pdm_pkg::PDM_SWSTBY:
        begin
          if (pin_lvl[pdm_pkg::PIN_NMI] || irq_wake)
          begin
            next_mode = pdm_pkg::PDM_OSCWAIT;
          end
        end
        pdm_pkg::PDM_OSCWAIT:
        begin
          if (stab_done)
          begin
            next_mode = pdm_pkg::PDM_RUN;
          end
        end
        pdm_pkg::PDM_RESET:
        begin
          next_mode = pdm_pkg::PDM_RUN;
        end
        pdm_pkg::PDM_HWSTBY:
        begin
          next_mode = pdm_pkg::PDM_RESET;
        end
        default:
        begin
          next_mode = pdm_pkg::PDM_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= pdm_pkg::PDM_RESET;
    end
    else if (ce)
    begin
      mode <= next_mode;
    end
  end

  // ==========================================================================
  // Stabilization counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stab_cnt <= '0;
    end
    else if (ce)
    begin
      if (mode == pdm_pkg::PDM_OSCWAIT && !stab_done)
      begin
        stab_cnt <= CW'(stab_cnt + 1'b1);
      end
      else
      begin
        stab_cnt <= '0;
      end
    end
  end

  // ==========================================================================
  // Mode outputs, registered from the next mode so they align with it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_halt                <= 1'b1;
      chip_reset              <= 1'b1;
      osc_enable              <= 1'b1;
      peripheral_clock_enable <= 1'b1;
      serial_converter_init   <= 1'b0;
      int_exception_start     <= 1'b0;
      reset_exception_start   <= 1'b0;
    end
    else if (ce)
    begin
      cpu_halt                <= next_mode != pdm_pkg::PDM_RUN;
      chip_reset              <= next_mode == pdm_pkg::PDM_RESET
                                 || next_mode == pdm_pkg::PDM_HWSTBY;
      osc_enable              <= next_mode != pdm_pkg::PDM_SWSTBY
                                 && next_mode != pdm_pkg::PDM_HWSTBY;
      peripheral_clock_enable <= next_mode == pdm_pkg::PDM_RUN
                                 || next_mode == pdm_pkg::PDM_SLEEP
                                 || next_mode == pdm_pkg::PDM_RESET;
      serial_converter_init   <= next_mode == pdm_pkg::PDM_SWSTBY;
      int_exception_start     <= next_mode == pdm_pkg::PDM_RUN
                                 && (mode == pdm_pkg::PDM_SLEEP
                                 || mode == pdm_pkg::PDM_OSCWAIT);
      reset_exception_start   <= next_mode == pdm_pkg::PDM_RUN
                                 && mode == pdm_pkg::PDM_RESET;
    end
  end

  // ==========================================================================
  // Register bus: one wait cycle, then a one-cycle answer
  assign ack = (avs_read || avs_write) && !avs_waitrequest;

  always_comb
  begin
    case (avs_address)
      pdm_pkg::OFS_MSTOP_A: rd_val = module_stop_control_a;
      pdm_pkg::OFS_MSTOP_B: rd_val = module_stop_control_b;
      pdm_pkg::OFS_MSTOP_C: rd_val = module_stop_control_c;
      pdm_pkg::OFS_SYSCLK:  rd_val = {5'h00, cpu_clock_divider_select};
      pdm_pkg::OFS_STANDBY: rd_val = {standby_select_bit, stabilize_time_select, 4'h0};
      pdm_pkg::OFS_STATUS:  rd_val = {3'h0, osc_enable, medium_speed, mode};
      default:              rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        avs_readdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // ==========================================================================
  // Control registers
  // Reset and hardware standby put every control back to its reset value,
  // which also cancels medium-speed operation.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      module_stop_control_a    <= pdm_pkg::MSTOP_A_RESET;
      module_stop_control_b    <= pdm_pkg::MSTOP_B_RESET;
      module_stop_control_c    <= pdm_pkg::MSTOP_C_RESET;
      cpu_clock_divider_select <= pdm_pkg::DIV_RESET;
      standby_select_bit       <= 1'b0;
      stabilize_time_select    <= pdm_pkg::STS_RESET;
    end
    else if (ce)
    begin
      if (in_reset)
      begin
        module_stop_control_a    <= pdm_pkg::MSTOP_A_RESET;
        module_stop_control_b    <= pdm_pkg::MSTOP_B_RESET;
        module_stop_control_c    <= pdm_pkg::MSTOP_C_RESET;
        cpu_clock_divider_select <= pdm_pkg::DIV_RESET;
        standby_select_bit       <= 1'b0;
        stabilize_time_select    <= pdm_pkg::STS_RESET;
      end
      else if (ack && avs_write && avs_byteenable[0])
      begin
        case (avs_address)
          pdm_pkg::OFS_MSTOP_A: module_stop_control_a <= avs_writedata[7:0];
          pdm_pkg::OFS_MSTOP_B: module_stop_control_b <= avs_writedata[7:0];
          pdm_pkg::OFS_MSTOP_C: module_stop_control_c <= avs_writedata[7:0];
          pdm_pkg::OFS_SYSCLK:
          begin
            cpu_clock_divider_select <= avs_writedata[pdm_pkg::DIV_LSB +: 3];
          end
          pdm_pkg::OFS_STANDBY:
          begin
            standby_select_bit <= avs_writedata[pdm_pkg::SSEL_BIT];
            if (avs_writedata[pdm_pkg::STS_LSB +: 3] != pdm_pkg::STS_NO_SET)
            begin
              stabilize_time_select <= avs_writedata[pdm_pkg::STS_LSB +: 3];
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Bus cycle boundary: divider and module stop changes take effect here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eff_div         <= pdm_pkg::DIV_RESET;
      medium_speed    <= 1'b0;
      peripheral_stop <= 6'h3F;
    end
    else if (ce)
    begin
      if (in_reset)
      begin
        eff_div         <= pdm_pkg::DIV_RESET;
        medium_speed    <= 1'b0;
        peripheral_stop <= 6'h3F;
      end
      else if (bus_cycle_end)
      begin
        eff_div         <= cpu_clock_divider_select;
        medium_speed    <= cpu_clock_divider_select != 3'h0
                           && cpu_clock_divider_select <= pdm_pkg::DIV_MAX;
        peripheral_stop <= {module_stop_control_c[pdm_pkg::CAN_BIT],
                            module_stop_control_b[pdm_pkg::SER2_BIT],
                            module_stop_control_b[pdm_pkg::SER1_BIT],
                            module_stop_control_b[pdm_pkg::SER0_BIT],
                            module_stop_control_a[pdm_pkg::CONV_BIT],
                            module_stop_control_a[pdm_pkg::TIMER_BIT]};
      end
    end
  end

  // ==========================================================================
  // Bus master clock enable
  // Bus masters stop with the CPU clocks in standby; the divider itself only
  // ever sees codes that changed at a bus cycle boundary or were cleared by reset.
  assign cif.div_code    = eff_div;
  assign bm_clock_enable = cif.bm_tick;

  pdm_divider u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .run   (peripheral_clock_enable),
    .cif   (cif)
  );

  // ==========================================================================
  // Checks
  property p_stop_write;
    (ce && ack && avs_write && avs_byteenable[0] && avs_address == pdm_pkg::OFS_MSTOP_B
     && !in_reset) |=> module_stop_control_b == $past(avs_writedata[7:0]);
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stop write lost");

  property p_reset_vals;
    (ce && mode == pdm_pkg::PDM_RESET) |=> (module_stop_control_a == 8'h3F
      && module_stop_control_c == 8'hFF);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_div_boundary;
    (ce && bus_cycle_end && !in_reset) |=> eff_div == $past(cpu_clock_divider_select);
  endproperty
  a_div_boundary: assert property (p_div_boundary) else $error("divider not applied");

  property p_stop_map;
    (ce && bus_cycle_end && !in_reset) |=>
      peripheral_stop[5] == $past(module_stop_control_c[3])
      && peripheral_stop[0] == $past(module_stop_control_a[5]);
  endproperty
  a_stop_map: assert property (p_stop_map) else $error("stop map wrong");

  property p_wdt_cancel;
    (ce && hw_standby_pin_n && pin_lvl[pdm_pkg::PIN_HWSTB] && wdt_reset)
      |=> mode == pdm_pkg::PDM_RESET ##1 (!ce || eff_div == 3'h0);
  endproperty
  a_wdt_cancel: assert property (p_wdt_cancel) else $error("reset missed");

  property p_hwstby;
    (ce && !pin_lvl[pdm_pkg::PIN_HWSTB]) |=> mode == pdm_pkg::PDM_HWSTBY && chip_reset;
  endproperty
  a_hwstby: assert property (p_hwstby) else $error("hw standby missed");

  property p_sleep_state;
    mode == pdm_pkg::PDM_SLEEP |-> cpu_halt && peripheral_clock_enable;
  endproperty
  a_sleep_state: assert property (p_sleep_state) else $error("sleep outputs");

  property p_swstby_state;
    mode == pdm_pkg::PDM_SWSTBY |-> !osc_enable && !peripheral_clock_enable
      && serial_converter_init;
  endproperty
  a_swstby_state: assert property (p_swstby_state) else $error("standby outputs");

  property p_sleep_wake;
    (ce && mode == pdm_pkg::PDM_SLEEP && pin_lvl[pdm_pkg::PIN_HWSTB]
     && pin_lvl[pdm_pkg::PIN_RST] && !wdt_reset && sleep_wake)
      |=> mode == pdm_pkg::PDM_RUN && int_exception_start;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake");

  property p_stab_bound;
    mode == pdm_pkg::PDM_OSCWAIT |-> stab_cnt < stab_target && !peripheral_clock_enable;
  endproperty
  a_stab_bound: assert property (p_stab_bound) else $error("stabilization overrun");

  property p_rst_standby;
    (ce && mode == pdm_pkg::PDM_SWSTBY && pin_lvl[pdm_pkg::PIN_HWSTB]
     && !pin_lvl[pdm_pkg::PIN_RST]) |=> osc_enable && peripheral_clock_enable;
  endproperty
  a_rst_standby: assert property (p_rst_standby) else $error("reset wake clocks");

  c_sleep_wake: cover property (mode == pdm_pkg::PDM_SLEEP ##1 mode == pdm_pkg::PDM_RUN);
  c_osc_done:   cover property (mode == pdm_pkg::PDM_OSCWAIT ##1 mode == pdm_pkg::PDM_RUN);
  c_medium:     cover property (medium_speed && bm_clock_enable);
  c_hwstby:     cover property (mode == pdm_pkg::PDM_HWSTBY);
endmodule // pdm_top

// >>> tb/pdm_partner.sv
/*
  Far side model: CPU sleep pulses, interrupt request and wake pins.
  Assumes one clock shared with the controller.
*/
`timescale 1ns/10ps
module pdm_partner (
  input  wire logic       clk,
  output      logic       sleep_exec = 1'b0,
  output      logic       int_request = 1'b0,
  output      logic       nmi_pin = 1'b0,
  output      logic       external_reset_pin_n = 1'b1,
  output      logic       hw_standby_pin_n = 1'b1,
  output      logic [5:0] irq_pin_n,
  output      logic [5:0] irq_enable
);
  // ==========================================================================
  // Pins
  // IRQ lines rest at their pull-up level; enables stay set so none is lost.
  assign irq_pin_n = 6'h3F;
  assign irq_enable = 6'h3F;
  task automatic pulse_sleep;
    @(posedge clk) sleep_exec <= 1'b1;
    @(posedge clk) sleep_exec <= 1'b0;
  endtask
  // The caller keeps reset low as long as the oscillator needs.
  task automatic drive(input logic nmi, irq, rst_n, hw_n);
    @(posedge clk);
    nmi_pin <= nmi;
    int_request <= irq;
    external_reset_pin_n <= rst_n;
    hw_standby_pin_n <= hw_n;
  endtask
endmodule // pdm_partner

// >>> tb/pdm_top_bench.sv
/*
  Bench for pdm_top: Avalon register tasks and mode sequences.
  Assumes the partner model drives the CPU and pin side.
*/
`timescale 1ns/10ps
module pdm_top_bench;
  logic        clk = 0, ce = 1, resetn = 0, avs_read = 0, avs_write = 0;
  logic        bus_cycle_end = 1, wdt_reset = 0, cpu_mask_all = 0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [5:0]  irq_enable, irq_pin_n, peripheral_stop;
  logic        avs_waitrequest, sleep_exec, int_request, nmi_pin, cpu_halt, chip_reset;
  logic        hw_standby_pin_n, external_reset_pin_n, osc_enable, medium_speed;
  logic        peripheral_clock_enable, bm_clock_enable, serial_converter_init;
  logic        int_exception_start, reset_exception_start;
  int          err_count = 0, comparisons = 0, n;
  always #25 clk = ~clk;
  pdm_top #(.STAB_BASE(8)) dut (.clk, .ce, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sleep_exec,
    .bus_cycle_end, .wdt_reset, .int_request, .cpu_mask_all, .irq_enable, .hw_standby_pin_n,
    .external_reset_pin_n, .nmi_pin, .irq_pin_n, .cpu_halt, .chip_reset, .osc_enable,
    .peripheral_clock_enable, .bm_clock_enable, .medium_speed, .serial_converter_init,
    .int_exception_start, .reset_exception_start, .peripheral_stop);
  pdm_partner far (.clk, .sleep_exec, .int_request, .nmi_pin, .external_reset_pin_n,
    .hw_standby_pin_n, .irq_pin_n, .irq_enable);
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every wait is bounded so a hung mode machine ends the run.
  task automatic bus(input logic wr, input logic [7:0] a, d);
    int k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++k < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 50)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_sim();
    end
  endtask
  function automatic logic pick(int w);
    return w == 0 ? osc_enable : w == 1 ? int_exception_start : w == 2 ? cpu_halt : chip_reset;
  endfunction
  task automatic wait_for(input int w, input logic v);
    n = 0;
    while (pick(w) !== v && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      end_sim();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    bus(0, pdm_pkg::OFS_MSTOP_A, 8'h00);
    chk(q, {24'h00_0000, pdm_pkg::MSTOP_A_RESET});
    bus(0, pdm_pkg::OFS_MSTOP_C, 8'h00);
    chk(q, 32'h0000_00FF);
    bus(0, 8'h20, 8'h00);
    chk(q, 32'h0000_0000);
    bus(1, pdm_pkg::OFS_MSTOP_A, 8'h1D);
    bus(1, pdm_pkg::OFS_MSTOP_B, 8'h1F);
    bus(1, pdm_pkg::OFS_MSTOP_C, 8'hF7);
    repeat (2) @(posedge clk);
    chk(peripheral_stop, 6'h00);
    bus(0, pdm_pkg::OFS_MSTOP_B, 8'h00);
    chk(q, 32'h0000_001F);
    $display("module stop test done");
    bus(1, pdm_pkg::OFS_SYSCLK, 8'h02);
    repeat (2) @(posedge clk);
    chk(medium_speed, 1'b1);
    bus(1, pdm_pkg::OFS_STANDBY, 8'h00);
    far.pulse_sleep();
    wait_for(2, 1'b1);
    chk(peripheral_clock_enable, 1'b1);
    cpu_mask_all <= 1'b1;
    far.drive(0, 1, 1, 1);
    repeat (3) @(posedge clk);
    chk(cpu_halt, 1'b1);
    cpu_mask_all <= 1'b0;
    wait_for(1, 1'b1);
    chk(medium_speed, 1'b1);
    far.drive(0, 0, 1, 1);
    $display("sleep test done");
    bus(1, pdm_pkg::OFS_STANDBY, 8'hD0);
    far.pulse_sleep();
    wait_for(0, 1'b0);
    chk(serial_converter_init, 1'b1);
    far.drive(1, 0, 1, 1);
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    chk(n, 256);
    chk(medium_speed, 1'b1);
    far.drive(0, 0, 1, 1);
    $display("standby test done");
    far.drive(0, 0, 0, 1);
    wait_for(3, 1'b1);
    @(posedge clk);
    chk(medium_speed, 1'b0);
    far.drive(0, 0, 1, 0);
    repeat (6) @(posedge clk);
    chk(osc_enable, 1'b0);
    far.drive(0, 0, 1, 1);
    wait_for(3, 1'b0);
    chk(reset_exception_start, 1'b1);
    bus(1, pdm_pkg::OFS_SYSCLK, 8'h02);
    repeat (2) @(posedge clk);
    chk(medium_speed, 1'b1);
    n = 0;
    repeat (16)
    begin
      @(posedge clk);
      if (bm_clock_enable === 1'b1)
        n++;
    end
    chk(n, 4);
    bus(1, pdm_pkg::OFS_SYSCLK, 8'h00);
    repeat (2) @(posedge clk);
    chk(medium_speed, 1'b0);
    bus(1, pdm_pkg::OFS_SYSCLK, 8'h02);
    wdt_reset <= 1'b1;
    @(posedge clk);
    wdt_reset <= 1'b0;
    wait_for(3, 1'b1);
    @(posedge clk);
    chk(medium_speed, 1'b0);
    $display("reset test done");
    end_sim();
  end
endmodule // pdm_top_bench
